/* File: cpsr_checker.sv */
// Purpose: Port-level checks for the core PC, stack and status block.
// Assumes: Byte address is four times the register index.
// Notes:   Sees only the ports of cpsr_core.
`timescale 1ns/1ps

module cpsr_checker
	import cpsr_pkg::*;
(
	input wire logic            clk_i,
	input wire logic            rst_i,
	input wire cpsr_seq_s       seq_i,
	input wire logic [PC_W-1:0] pc_o,
	input wire cpsr_data_s      data_i,
	input wire logic            mem_valid_o,
	input wire logic            mem_we_o,
	input wire logic [7:0]      mem_wdata_o,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic            wb_we_i,
	input wire logic [31:0]     wb_adr_i,
	input wire logic [3:0]      wb_sel_i,
	input wire logic [31:0]     wb_dat_i,
	input wire logic [31:0]     wb_dat_o,
	input wire logic            wb_ack_o,
	input wire logic            wb_err_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A request is taken only when no answer is pending.
	wire logic tk  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire logic pcw = tk && wb_we_i && wb_sel_i[0] && (wb_adr_i == 32'h0000_0008);

	property p_take; tk |=> wb_ack_o || wb_err_o; endproperty
	a_take: assert property (p_take) else $error("bus request not answered");
	property p_pulse; wb_ack_o |=> !wb_ack_o && !wb_err_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
	property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_err; tk && wb_adr_i == 32'h0000_0000 |=> wb_err_o && !wb_ack_o; endproperty
	a_err: assert property (p_err) else $error("window reached over bus");
	property p_rst; $fell(rst_i) |-> pc_o == RST_PC; endproperty
	a_rst: assert property (p_rst) else $error("pc not cleared by reset");
	property p_pcw; pcw |=> pc_o[7:0] == $past(wb_dat_i[7:0]); endproperty
	a_pcw: assert property (p_pcw) else $error("pc low byte not loaded");
	property p_jump; seq_i.op == CPSR_PC_JUMP && !pcw |=> pc_o[10:0] == $past(seq_i.target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded");
	property p_vec; seq_i.op == CPSR_PC_IRQ && !pcw |=> pc_o == $past(seq_i.irq_vector);
	endproperty
	a_vec: assert property (p_vec) else $error("interrupt vector not loaded");
	property p_mem;
		mem_valid_o |-> mem_we_o == $past(data_i.we) && mem_wdata_o == $past(data_i.wdata);
	endproperty
	a_mem: assert property (p_mem) else $error("indirect access mangled");
	property p_idle; !data_i.valid |=> !mem_valid_o; endproperty
	a_idle: assert property (p_idle) else $error("spurious data access");
endmodule : cpsr_checker

/* File: cpsr_core.sv */
// Purpose: PC with high latch, circular return stack, indirect addressing,
//          comparator interrupt bits and reset-cause status.
// Assumes: Classic Wishbone slave, 32-bit data, single clock, sync reset.
// Notes:   Registers sit in byte lane 0 of the bus word; upper lanes read zero.
//          The bus answers one cycle after a request is taken.
// Functional notes
// R1: Comparator interrupt enable at peripheral_enable bit 6, reset 0, read/write.
// R2: Unused bits 7 and 5..0 of enable and flag registers read zero.
// R3: Comparator flag bit 6 sets on comparator input change, else reads 0.
// R4: Flags set regardless of their enable or the global enable.
// R5: Power-on status bit 1 cleared on power-on reset, keeps software writes.
// R6: Brown-out status bit 0 cleared on brown-out reset; software sets it.
// R7: Brown-out bit meaningless when the brown-out fuse disables the circuit.
// R8: Reset status bits 7..2 read zero.
// R9: 13-bit PC; low byte readable/writable, upper five bits from high latch.
// R10: Whole program counter cleared on every reset.
// R11: Writing the PC low byte loads PC 12..8 from high latch 4..0.
// R12: Call or jump takes only high latch bits 4..3 into upper PC.
// R13: Eight-entry 13-bit return stack, pointer not visible to software.
// R14: Push on call or interrupt branch, pop on any return kind.
// R15: High latch untouched by push and pop.
// R16: Stack is circular; ninth push overwrites the first.
// R17: No overflow or underflow indication exists.
// R18: Indirect window access goes to location named by file pointer.
// R19: Indirect read of the window itself gives 00h, write stores nothing.
// R20: Indirect address is bank bit plus 8-bit pointer; bank bit unused.
// R21: Software clears pending flags before enabling the interrupt.
// R22: Interrupt request needs flag, enable, peripheral and global enables.
// R23: Call or jump loads the low 11 PC bits from the instruction.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps

module cpsr_core
	import cpsr_pkg::*;
#(
	parameter int STACK_DEPTH = STACK_D
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Reset causes, valid while rst_i is high
	input  wire logic              por_reset_i,
	input  wire logic              bor_reset_i,
	// Comparator change event, one cycle
	input  wire logic              cmp_change_i,
	// Instruction sequencer
	input  wire cpsr_seq_s         seq_i,
	output logic [PC_W-1:0]        pc_o,
	output logic                   cmp_irq_req_o,
	// Indirect data path to data memory
	input  wire cpsr_data_s        data_i,
	output logic                   mem_valid_o,
	output logic                   mem_we_o,
	output logic [8:0]             mem_addr_o,
	output logic [7:0]             mem_wdata_o,
	// Wishbone classic slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [31:0]       wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	output logic                   wb_err_o
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	// -----------------------------------------------------------------
	// Register state
	// -----------------------------------------------------------------
	logic                  cmp_irq_enable_ff;
	logic                  cmp_irq_flag_ff;
	logic                  por_status_ff;
	logic                  brownout_status_ff;
	logic [7:0]            pc_high_latch_ff;
	logic [7:0]            file_pointer_ff;
	logic                  indirect_bank_bit_ff;
	logic                  global_irq_enable_ff;
	logic                  periph_irq_enable_ff;
	logic [PC_W-1:0]       pc_ff;
	logic [PC_W-1:0]       stack_mem [STACK_DEPTH];
	logic [SP_W-1:0]       sp_ff;

	// -----------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------
	logic       bus_req;
	logic       bus_wr;
	logic       lane0_wr;
	logic [7:0] reg_idx;
	logic       idx_hit;
	logic       mapped;

	assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign reg_idx  = wb_adr_i[9:2];
	assign idx_hit  = (wb_adr_i[31:10] == 22'h00_0000) && (wb_adr_i[1:0] == 2'b00);
	assign bus_wr   = bus_req && mapped && wb_we_i;
	assign lane0_wr = bus_wr && wb_sel_i[0];

	// The window index is left out on purpose: it is reached only through the
	// pointer, so a bus access to it answers with an error.
	always_comb begin
		mapped = 1'b0;
		if (idx_hit) begin
			case (reg_idx)
				REG_PERIPHERAL_FLAG,
				REG_PERIPHERAL_ENABLE,
				REG_RESET_CAUSE,
				REG_PC_LOW_BYTE,
				REG_PC_HIGH_LATCH,
				REG_FILE_POINTER,
				REG_IRQ_CONTROL,
				REG_STATUS_BANK: mapped = 1'b1;
				default:         mapped = 1'b0;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Register write strobes
	// -----------------------------------------------------------------
	// A write with lane 0 disabled is answered but changes nothing.
	logic wr_flag;
	logic wr_enable;
	logic wr_cause;
	logic wr_pc_low;
	logic wr_latch;
	logic wr_pointer;
	logic wr_irq_ctrl;
	logic wr_bank;

	assign wr_flag     = lane0_wr && (reg_idx == REG_PERIPHERAL_FLAG);
	assign wr_enable   = lane0_wr && (reg_idx == REG_PERIPHERAL_ENABLE);
	assign wr_cause    = lane0_wr && (reg_idx == REG_RESET_CAUSE);
	assign wr_pc_low   = lane0_wr && (reg_idx == REG_PC_LOW_BYTE);
	assign wr_latch    = lane0_wr && (reg_idx == REG_PC_HIGH_LATCH);
	assign wr_pointer  = lane0_wr && (reg_idx == REG_FILE_POINTER);
	assign wr_irq_ctrl = lane0_wr && (reg_idx == REG_IRQ_CONTROL);
	assign wr_bank     = lane0_wr && (reg_idx == REG_STATUS_BANK);

	// -----------------------------------------------------------------
	// Interrupt enable and flag
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_irq_enable_ff <= RST_BYTE[CMP_IRQ_BIT]; // [R1]
		end else if (wr_enable) begin
			cmp_irq_enable_ff <= wb_dat_i[CMP_IRQ_BIT]; // [R1]
		end
	end

	// The change event beats a simultaneous software clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_irq_flag_ff <= RST_BYTE[CMP_IRQ_BIT];
		end else if (cmp_change_i) begin
			cmp_irq_flag_ff <= 1'b1; // [R3] [R4]
		end else if (wr_flag) begin
			cmp_irq_flag_ff <= wb_dat_i[CMP_IRQ_BIT]; // [R22]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_irq_enable_ff <= RST_BYTE[GLOBAL_IRQ_BIT];
		end else if (wr_irq_ctrl) begin
			global_irq_enable_ff <= wb_dat_i[GLOBAL_IRQ_BIT]; // [R22]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			periph_irq_enable_ff <= RST_BYTE[PERIPH_IRQ_BIT];
		end else if (wr_irq_ctrl) begin
			periph_irq_enable_ff <= wb_dat_i[PERIPH_IRQ_BIT]; // [R22]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_irq_req_o <= 1'b0;
		end else begin
			cmp_irq_req_o <= cmp_irq_flag_ff && cmp_irq_enable_ff &&
				periph_irq_enable_ff && global_irq_enable_ff; // [R22]
		end
	end

	// -----------------------------------------------------------------
	// Reset-cause status
	// -----------------------------------------------------------------
	// A reset that is neither power-on nor brown-out keeps both bits. The
	// brown-out bit starts at one after power-on; software must still set it,
	// and with the fuse off its value is not to be trusted.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			if (por_reset_i) begin
				por_status_ff <= 1'b0; // [R5]
			end
		end else if (wr_cause) begin
			por_status_ff <= wb_dat_i[POR_STATUS_BIT]; // [R5]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			if (por_reset_i) begin
				brownout_status_ff <= RST_RESET_CAUSE[BROWNOUT_BIT]; // [R6] [R7]
			end else if (bor_reset_i) begin
				brownout_status_ff <= 1'b0; // [R6]
			end
		end else if (wr_cause) begin
			brownout_status_ff <= wb_dat_i[BROWNOUT_BIT]; // [R6]
		end
	end

	// -----------------------------------------------------------------
	// High latch, file pointer and bank bit
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_high_latch_ff <= RST_BYTE;
		end else if (wr_latch) begin
			pc_high_latch_ff <= wb_dat_i[7:0]; // [R15]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			file_pointer_ff <= RST_BYTE;
		end else if (wr_pointer) begin
			file_pointer_ff <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			indirect_bank_bit_ff <= RST_BYTE[BANK_BIT];
		end else if (wr_bank) begin
			indirect_bank_bit_ff <= wb_dat_i[BANK_BIT];
		end
	end

	// -----------------------------------------------------------------
	// Program counter and return stack
	// -----------------------------------------------------------------
	logic [PC_W-1:0] nxt_pc;
	logic [PC_W-1:0] pc_inc;
	logic [PC_W-1:0] jump_pc;
	logic [SP_W-1:0] sp_dec;

	assign pc_inc  = pc_ff + PC_W'(1);
	assign jump_pc = {pc_high_latch_ff[4:3], seq_i.target}; // [R12] [R23]
	assign sp_dec  = sp_ff - SP_W'(1);

	// A low-byte write overrides the sequencer in the same cycle.
	// The push or pop of that cycle is dropped with it.
	always_comb begin
		nxt_pc = pc_ff;
		if (wr_pc_low) begin
			nxt_pc = {pc_high_latch_ff[4:0], wb_dat_i[7:0]}; // [R9] [R11]
		end else begin
			case (seq_i.op)
				CPSR_PC_STEP: nxt_pc = pc_inc;
				CPSR_PC_HOLD: nxt_pc = pc_ff;
				CPSR_PC_JUMP: nxt_pc = jump_pc; // [R12]
				CPSR_PC_CALL: nxt_pc = jump_pc; // [R12]
				CPSR_PC_IRQ:  nxt_pc = seq_i.irq_vector;
				CPSR_PC_RET:  nxt_pc = stack_mem[sp_dec]; // [R14]
				default:      nxt_pc = pc_ff;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_ff <= RST_PC; // [R10]
			pc_o  <= RST_PC; // [R10]
		end else begin
			pc_ff <= nxt_pc;
			pc_o  <= nxt_pc;
		end
	end

	// The pointer wraps silently and is never visible on the bus, so
	// overflow and underflow leave no trace.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_ff <= '0; // [R13]
		end else if (!wr_pc_low) begin
			if (seq_i.op == CPSR_PC_CALL || seq_i.op == CPSR_PC_IRQ) begin
				sp_ff <= sp_ff + SP_W'(1); // [R16] [R17]
			end else if (seq_i.op == CPSR_PC_RET) begin
				sp_ff <= sp_dec; // [R14] [R17]
			end
		end
	end

	// Return address is the next instruction after a call, and the current PC for an interrupt branch.
	always_ff @(posedge clk_i) begin
		if (!rst_i && !wr_pc_low &&
			(seq_i.op == CPSR_PC_CALL || seq_i.op == CPSR_PC_IRQ)) begin
			stack_mem[sp_ff] <= (seq_i.op == CPSR_PC_CALL) ? pc_inc : pc_ff; // [R13] [R14] [R16]
		end
	end

	// -----------------------------------------------------------------
	// Indirect addressing
	// -----------------------------------------------------------------
	logic [8:0] ind_addr;
	logic       ind_self;
	logic       ind_access;

	assign ind_addr   = {indirect_bank_bit_ff, file_pointer_ff}; // [R20]
	assign ind_self   = (file_pointer_ff == REG_INDIRECT_WINDOW);
	assign ind_access = data_i.valid && (data_i.addr == REG_INDIRECT_WINDOW);

	// Only the pointer selects the location; the bank bit is carried out but
	// this device family has no second bank to reach.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_valid_o <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= 9'h000;
			mem_wdata_o <= RST_BYTE;
		end else begin
			mem_valid_o <= data_i.valid && !(ind_access && ind_self); // [R18] [R19]
			mem_we_o    <= data_i.we;
			mem_addr_o  <= ind_access ? ind_addr : {1'b0, data_i.addr}; // [R18]
			mem_wdata_o <= data_i.wdata;
		end
	end

	// -----------------------------------------------------------------
	// Bus answer
	// -----------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		// Unused bits keep this zero default, so they always read back as zero.
		rd_byte = 8'h00;
		case (reg_idx)
			REG_PERIPHERAL_FLAG:   rd_byte[CMP_IRQ_BIT] = cmp_irq_flag_ff; // [R2] [R3]
			REG_PERIPHERAL_ENABLE: rd_byte[CMP_IRQ_BIT] = cmp_irq_enable_ff; // [R2]
			REG_RESET_CAUSE:       rd_byte = {6'b00_0000, por_status_ff,
				brownout_status_ff}; // [R8]
			REG_PC_LOW_BYTE:       rd_byte = pc_ff[7:0]; // [R9]
			REG_PC_HIGH_LATCH:     rd_byte = {3'b000, pc_high_latch_ff[4:0]};
			REG_FILE_POINTER:      rd_byte = file_pointer_ff;
			REG_IRQ_CONTROL:       rd_byte = {global_irq_enable_ff,
				periph_irq_enable_ff, 6'b00_0000};
			REG_STATUS_BANK:       rd_byte[BANK_BIT] = indirect_bank_bit_ff;
			default:               rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req && mapped;
			wb_err_o <= bus_req && !mapped;
		end
	end

	// Read data is forced to zero outside a read answer so no stale byte leaks.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && mapped && !wb_we_i) begin
			wb_dat_o <= {24'h00_0000, rd_byte};
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

endmodule : cpsr_core

/* File: cpsr_core_tb_top.sv */
// Purpose: Directed testbench for cpsr_core.
// Assumes: Classic Wishbone, answer within a few cycles.
// Notes:   Sequencer ops are held one cycle, then HOLD.
`timescale 1ns/1ps

module cpsr_core_tb_top
	import cpsr_pkg::*;
;
	logic            clk_i        = 1'b0;
	logic            rst_i        = 1'b1;
	logic            por_reset_i  = 1'b1;
	logic            bor_reset_i  = 1'b0;
	logic            cmp_change_i = 1'b0;
	cpsr_seq_s       seq_i        = '{CPSR_PC_HOLD, 11'h000, 13'h0000};
	cpsr_data_s      data_i       = '0;
	logic            wb_cyc_i     = 1'b0;
	logic            wb_stb_i     = 1'b0;
	logic            wb_we_i      = 1'b0;
	logic [31:0]     wb_adr_i     = 32'h0000_0000;
	logic [3:0]      wb_sel_i     = 4'hf;
	logic [31:0]     wb_dat_i     = 32'h0000_0000;
	logic [PC_W-1:0] pc_o;
	logic            cmp_irq_req_o, mem_valid_o, mem_we_o, wb_ack_o, wb_err_o;
	logic [8:0]      mem_addr_o;
	logic [7:0]      mem_wdata_o;
	logic [31:0]     wb_dat_o;
	int              num_errors = 0;
	int              cmp_count  = 0;

	always #2 clk_i = ~clk_i;

	cpsr_core i_dut (.clk_i, .rst_i, .por_reset_i, .bor_reset_i, .cmp_change_i, .seq_i,
		.pc_o, .cmp_irq_req_o, .data_i, .mem_valid_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .wb_err_o);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] dat,
			output logic [31:0] rd, output logic er);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= {22'h0, idx, 2'b00};
		wb_dat_i <= {24'h00_0000, dat};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		logic [31:0] rd;
		logic        er;
		wb(1'b1, idx, dat, rd, er);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		logic        er;
		wb(1'b0, idx, 8'h00, rd, er);
		chk(rd, {24'h00_0000, exp});
	endtask : rdc

	task automatic do_reset(input logic por, input logic bor);
		@(posedge clk_i);
		rst_i       <= 1'b1;
		por_reset_i <= por;
		bor_reset_i <= bor;
		repeat (10) @(posedge clk_i);
		rst_i       <= 1'b0;
		por_reset_i <= 1'b0;
		bor_reset_i <= 1'b0;
		#1 chk(32'(pc_o), 32'h0000_0000);
	endtask : do_reset

	task automatic op(input cpsr_pc_op_e o, input logic [10:0] t, input logic [12:0] exp);
		@(posedge clk_i);
		seq_i <= '{o, t, 13'h0004};
		@(posedge clk_i);
		seq_i.op <= CPSR_PC_HOLD;
		#1 chk(32'(pc_o), 32'(exp));
	endtask : op

	task automatic pulse(output logic x);
		@(posedge clk_i) cmp_change_i <= 1'b1;
		@(posedge clk_i) cmp_change_i <= 1'b0;
		x = 1'b0;
	endtask : pulse

	task automatic t_reset;
		do_reset(1'b1, 1'b0);
		rdc(REG_PERIPHERAL_FLAG, 8'h00);
		rdc(REG_PERIPHERAL_ENABLE, 8'h00);
		rdc(REG_RESET_CAUSE, 8'h01);
		wr(REG_RESET_CAUSE, 8'hff);
		rdc(REG_RESET_CAUSE, 8'h03);
		wr(REG_PERIPHERAL_ENABLE, 8'hff);
		rdc(REG_PERIPHERAL_ENABLE, 8'h40);
		wr(REG_PERIPHERAL_FLAG, 8'hbf);
		rdc(REG_PERIPHERAL_FLAG, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_cmp;
		logic x;
		wr(REG_PERIPHERAL_ENABLE, 8'h00);
		pulse(x);
		rdc(REG_PERIPHERAL_FLAG, 8'h40);
		#1 chk(32'(cmp_irq_req_o), 32'h0000_0000);
		wr(REG_PERIPHERAL_FLAG, 8'h00);
		wr(REG_PERIPHERAL_ENABLE, 8'h40);
		wr(REG_IRQ_CONTROL, 8'hc0);
		pulse(x);
		repeat (2) @(posedge clk_i);
		#1 chk(32'(cmp_irq_req_o), 32'h0000_0001);
		wr(REG_PERIPHERAL_FLAG, 8'h00);
		repeat (2) @(posedge clk_i);
		#1 chk(32'(cmp_irq_req_o), 32'h0000_0000);
		fork
			wr(REG_PERIPHERAL_FLAG, 8'h00);
			pulse(x);
		join
		rdc(REG_PERIPHERAL_FLAG, 8'h40);
		wr(REG_PERIPHERAL_FLAG, 8'h00);
		$display("test comparator done");
	endtask : t_cmp

	task automatic t_pc;
		wr(REG_PC_HIGH_LATCH, 8'h1f);
		wr(REG_PC_LOW_BYTE, 8'h34);
		#1 chk(32'(pc_o), 32'h0000_1f34);
		op(CPSR_PC_JUMP, 11'h123, 13'h1923);
		op(CPSR_PC_STEP, 11'h000, 13'h1924);
		rdc(REG_PC_LOW_BYTE, 8'h24);
		$display("test pc done");
	endtask : t_pc

	// Ten calls wrap the stack, so the last two pushes hide the first two.
	task automatic t_stack;
		logic [12:0] ex [10];
		logic [12:0] cur;
		int          i;
		op(CPSR_PC_IRQ, 11'h000, 13'h0004);
		op(CPSR_PC_RET, 11'h000, 13'h1924);
		cur = 13'h1924;
		for (i = 0; i < 10; i++) begin
			ex[i] = cur + 13'h0001;
			cur   = {2'b11, 11'(i * 16 + 1)};
			op(CPSR_PC_CALL, 11'(i * 16 + 1), cur);
		end
		for (i = 9; i >= 2; i--) op(CPSR_PC_RET, 11'h000, ex[i]);
		op(CPSR_PC_RET, 11'h000, ex[9]);
		rdc(REG_PC_HIGH_LATCH, 8'h1f);
		$display("test stack done");
	endtask : t_stack

	task automatic t_ind;
		logic [31:0] rd;
		logic        er;
		wr(REG_FILE_POINTER, 8'h25);
		@(posedge clk_i) data_i <= '{1'b1, 1'b1, 8'h00, 8'h5a};
		@(posedge clk_i) data_i <= '0;
		#1 chk({13'h0, mem_valid_o, mem_we_o, mem_addr_o, mem_wdata_o},
			{13'h0, 2'b11, 9'h025, 8'h5a});
		wr(REG_FILE_POINTER, 8'h00);
		@(posedge clk_i) data_i <= '{1'b1, 1'b1, 8'h00, 8'h77};
		@(posedge clk_i) data_i <= '0;
		#1 chk(32'(mem_valid_o), 32'h0000_0000);
		wb(1'b0, REG_INDIRECT_WINDOW, 8'h00, rd, er);
		chk(32'(er), 32'h0000_0001);
		do_reset(1'b0, 1'b1);
		rdc(REG_RESET_CAUSE, 8'h02);
		rdc(REG_PERIPHERAL_ENABLE, 8'h00);
		$display("test indirect and brown-out done");
	endtask : t_ind

	task automatic summarize;
		$display("checks=%0d errors=%0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	initial begin
		t_reset();
		t_cmp();
		t_pc();
		t_stack();
		t_ind();
		summarize();
	end

	initial begin
		#20000;
		num_errors++;
		summarize();
	end
endmodule : cpsr_core_tb_top

bind cpsr_core cpsr_checker i_chk (.clk_i, .rst_i, .seq_i, .pc_o, .data_i, .mem_valid_o,
	.mem_we_o, .mem_wdata_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o);

/* File: cpsr_pkg.sv */
// Purpose: Shared constants and types for the core PC, stack and status block.
// Assumes: 8-bit registers in the low byte of a 32-bit Wishbone word.
// Notes:   Byte address of a register is four times its printed offset.
package cpsr_pkg;

	// -----------------------------------------------------------------
	// Register indices
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_PERIPHERAL_FLAG   = 8'h0c;
	localparam logic [7:0] REG_PERIPHERAL_ENABLE = 8'h8c;
	localparam logic [7:0] REG_RESET_CAUSE       = 8'h8e;
	localparam logic [7:0] REG_PC_LOW_BYTE       = 8'h02;
	localparam logic [7:0] REG_PC_HIGH_LATCH     = 8'h0a;
	localparam logic [7:0] REG_FILE_POINTER      = 8'h04;
	localparam logic [7:0] REG_IRQ_CONTROL       = 8'h0b;
	localparam logic [7:0] REG_STATUS_BANK       = 8'h03;
	localparam logic [7:0] REG_INDIRECT_WINDOW   = 8'h00;

	// -----------------------------------------------------------------
	// Field positions and reset values
	// -----------------------------------------------------------------
	localparam int         CMP_IRQ_BIT      = 6;
	localparam int         GLOBAL_IRQ_BIT   = 7;
	localparam int         PERIPH_IRQ_BIT   = 6;
	localparam int         POR_STATUS_BIT   = 1;
	localparam int         BROWNOUT_BIT     = 0;
	localparam int         BANK_BIT         = 7;
	localparam logic [7:0] RST_BYTE         = 8'h00;
	localparam logic [7:0] RST_RESET_CAUSE  = 8'h03;
	localparam logic [12:0] RST_PC          = 13'h0000;

	localparam int PC_W      = 13;
	localparam int STACK_D   = 8;
	localparam int ADDR_LO_W = 11;

	// -----------------------------------------------------------------
	// Sequencer request to the program counter
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		CPSR_PC_STEP,
		CPSR_PC_HOLD,
		CPSR_PC_JUMP,
		CPSR_PC_CALL,
		CPSR_PC_IRQ,
		CPSR_PC_RET
	} cpsr_pc_op_e;

	typedef struct packed {
		cpsr_pc_op_e           op;
		logic [ADDR_LO_W-1:0]  target;
		logic [PC_W-1:0]       irq_vector;
	} cpsr_seq_s;

	// Indirect access from the instruction datapath.
	typedef struct packed {
		logic       valid;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cpsr_data_s;

endpackage : cpsr_pkg
